// ===== rtl/fpf_defs.vh
// ----------------------------------------------------------------
// Contract
// - level 0 protects nothing; levels 1..9 protect 2^(level-1) of 512 blocks.
// - top/bottom select 0 counts protected blocks down from block 511.
// - top/bottom select 1 counts protected blocks up from block 0.
// - levels 10..15 protect all 512 blocks, either selection.
// - function register: rows 3..0 locks, erase susp, prog susp, t/b, rst dis.
// - bits 1 and 7..4 are one-time: once 1, writes of 0 ignored.
// - bit 0 reset-pin disable: writable only while 0, package default, one-time.
// - reset-pin disable set moves reset onto the shared hold/reset pin.
// - top/bottom select resets to top; once bottom it cannot return.
// - program-suspend flag read-only; set on accepted suspend, clear on resume.
// - erase-suspend flag read-only; set on accepted suspend, clear on resume.
// - row lock bit 0 allows programming; 1 refuses programming of that row.
// - a set row lock bit can never be cleared.
// - program or erase into the protected area is inhibited.
// - whole-chip erase ignored unless protect level is zero.
// ----------------------------------------------------------------
`ifndef FPF_DEFS_VH
`define FPF_DEFS_VH
`define FPF_ADDR_FUNC     12'h000
`define FPF_ADDR_LEVEL    12'h004
`define FPF_ADDR_STATUS   12'h008
`define FPF_BIT_RSTDIS    0
`define FPF_BIT_TBS       1
`define FPF_BIT_PROGRAM_SUSPENDED_FLAG      2
`define FPF_BIT_ERASE_SUSPENDED_FLAG      3
`define FPF_LOCK_LSB      4
`define FPF_OTP_MASK      8'hf2
`define FPF_LEVEL_ALL     4'ha
`define FPF_BLOCK_BITS    9
`define FPF_LOCK_MSB      7
`define FPF_LEVEL_MSB     3
`define FPF_LEVEL_NONE    4'h0
`define FPF_LEVEL_ONE     4'h1
`define FPF_SPAN_ALL      10'h200
`define FPF_SPAN_NONE     10'h000
`define FPF_SPAN_ONE      10'h001
`define FPF_LAST_BLOCK    9'h1ff
`define FPF_TBS_RESET     1'b0
`define FPF_LOCK_RESET    1'b0
`endif

// ===== rtl/fpf_protect.v
`timescale 1ns/1ps
`include "fpf_defs.vh"

module fpf_protect #(
    parameter RSTDIS_DEFAULT = 1'b0
) (
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // operation check from the flash sequencer
    input  wire        op_req_in,
    input  wire        op_is_chip_erase_in,
    input  wire        op_is_info_row_in,
    input  wire [1:0]  op_info_row_in,
    input  wire [8:0]  op_block_in,
    output reg         op_allow_out,
    output reg         op_deny_out,
    // suspend events
    input  wire        prog_suspend_in,
    input  wire        prog_resume_in,
    input  wire        erase_suspend_in,
    input  wire        erase_resume_in,
    // reset pin routing
    output wire        reset_on_hold_pin_out
);

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    wire       wr_en;
    wire       rd_en;
    wire       mapped;
    wire       wr_func;
    wire       wr_level;
    reg  [3:0] level_ff;
    reg  [3:0] nxt_level;

    // the slave never stretches a transfer, so pready is a constant
    assign pready   = 1'b1;
    assign mapped   = (paddr == `FPF_ADDR_FUNC) ||
                      (paddr == `FPF_ADDR_LEVEL) ||
                      (paddr == `FPF_ADDR_STATUS);
    assign pslverr  = psel & penable & ~mapped;
    // writes land in the access phase; read data is fetched in setup
    assign wr_en    = psel & penable & pwrite & mapped;
    assign rd_en    = psel & ~penable & ~pwrite;
    assign wr_func  = wr_en & (paddr == `FPF_ADDR_FUNC);
    assign wr_level = wr_en & (paddr == `FPF_ADDR_LEVEL);

    // ------------------------------------------------------------
    // function register: one-time bits
    // ------------------------------------------------------------
    wire [7:0] func_word;
    wire [3:0] row_lock;
    wire       rstdis_bit;
    wire       tbs_bit;
    wire       program_suspended_flag_bit;
    wire       erase_suspended_flag_bit;

    // strap default of the reset-pin disable comes in as a parameter
    fpf_otp_bit #(
        .RESET_VALUE (RSTDIS_DEFAULT)
    ) i_rstdis (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .wr_in       (wr_func),
        .data_in     (pwdata[`FPF_BIT_RSTDIS]),
        .bit_out     (rstdis_bit)
    );

    // once bottom is chosen the protected area can never flip back
    fpf_otp_bit #(
        .RESET_VALUE (`FPF_TBS_RESET)
    ) i_tbs (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .wr_in       (wr_func),
        .data_in     (pwdata[`FPF_BIT_TBS]),
        .bit_out     (tbs_bit)
    );

    // each row lock guards one information row against programming
    fpf_otp_bit #(
        .RESET_VALUE (`FPF_LOCK_RESET)
    ) i_lock0 (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .wr_in       (wr_func),
        .data_in     (pwdata[`FPF_LOCK_LSB]),
        .bit_out     (row_lock[0])
    );

    fpf_otp_bit #(
        .RESET_VALUE (`FPF_LOCK_RESET)
    ) i_lock1 (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .wr_in       (wr_func),
        .data_in     (pwdata[`FPF_LOCK_LSB+1]),
        .bit_out     (row_lock[1])
    );

    fpf_otp_bit #(
        .RESET_VALUE (`FPF_LOCK_RESET)
    ) i_lock2 (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .wr_in       (wr_func),
        .data_in     (pwdata[`FPF_LOCK_LSB+2]),
        .bit_out     (row_lock[2])
    );

    fpf_otp_bit #(
        .RESET_VALUE (`FPF_LOCK_RESET)
    ) i_lock3 (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .wr_in       (wr_func),
        .data_in     (pwdata[`FPF_LOCK_LSB+3]),
        .bit_out     (row_lock[3])
    );

    // ------------------------------------------------------------
    // function register: volatile suspend flags
    // ------------------------------------------------------------
    // both flags are status only; a bus write never reaches them
    fpf_susp_flag i_program_suspended_flag (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .set_in      (prog_suspend_in),
        .clear_in    (prog_resume_in),
        .flag_out    (program_suspended_flag_bit)
    );

    fpf_susp_flag i_erase_suspended_flag (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .set_in      (erase_suspend_in),
        .clear_in    (erase_resume_in),
        .flag_out    (erase_suspended_flag_bit)
    );

    // ------------------------------------------------------------
    // function register assembly
    // ------------------------------------------------------------
    assign func_word[`FPF_BIT_RSTDIS] = rstdis_bit;
    assign func_word[`FPF_BIT_TBS]    = tbs_bit;
    assign func_word[`FPF_BIT_PROGRAM_SUSPENDED_FLAG]   = program_suspended_flag_bit;
    assign func_word[`FPF_BIT_ERASE_SUSPENDED_FLAG]   = erase_suspended_flag_bit;
    assign func_word[`FPF_LOCK_MSB:`FPF_LOCK_LSB] = row_lock;

    // the hold/reset pin takes over reset once the bit is set
    assign reset_on_hold_pin_out = rstdis_bit;

    // ------------------------------------------------------------
    // protect level register
    // ------------------------------------------------------------
    always @* begin
        nxt_level = level_ff;
        if (wr_level) begin
            nxt_level = pwdata[`FPF_LEVEL_MSB:0];
        end
    end

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            level_ff <= `FPF_LEVEL_NONE;
        end else begin
            level_ff <= nxt_level;
        end
    end

    // ------------------------------------------------------------
    // protection decode
    // ------------------------------------------------------------
    reg        in_range;
    reg  [8:0] prot_cnt;
    reg        deny_now;
    reg        denied_ff;
    wire [9:0] span;
    wire       chip_ok;
    wire       row_locked;

    assign span = (level_ff >= `FPF_LEVEL_ALL)  ? `FPF_SPAN_ALL  :
                  (level_ff == `FPF_LEVEL_NONE) ? `FPF_SPAN_NONE :
                  (`FPF_SPAN_ONE << (level_ff - `FPF_LEVEL_ONE));

    // top area counts down from the last block, bottom counts up
    always @* begin
        prot_cnt = `FPF_LAST_BLOCK - op_block_in;
        in_range = ({1'b0, prot_cnt} < span);
        if (tbs_bit) begin
            in_range = ({1'b0, op_block_in} < span);
        end
    end

    // chip erase is only honoured with no block protected at all
    assign chip_ok    = (level_ff == `FPF_LEVEL_NONE);
    assign row_locked = row_lock[op_info_row_in];

    // info rows and chip erase sit outside the block map
    always @* begin
        deny_now = in_range;
        if (op_is_info_row_in) begin
            deny_now = row_locked;
        end else if (op_is_chip_erase_in) begin
            deny_now = ~chip_ok;
        end
    end

    // ------------------------------------------------------------
    // check answer
    // ------------------------------------------------------------
    // denied_ff keeps the verdict of the last request for software
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            op_allow_out <= 1'b0;
            op_deny_out  <= 1'b0;
            denied_ff    <= 1'b0;
        end else begin
            op_allow_out <= op_req_in & ~deny_now;
            op_deny_out  <= op_req_in & deny_now;
            if (op_req_in) begin
                denied_ff <= deny_now;
            end
        end
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    wire [31:0] status_word;

    // all 512 blocks wrap to 0 in the nine-bit count field
    assign status_word = {22'h000000, denied_ff, span[`FPF_BLOCK_BITS-1:0]};

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                `FPF_ADDR_FUNC:   prdata <= {24'h000000, func_word};
                `FPF_ADDR_LEVEL:  prdata <= {28'h0000000, level_ff};
                `FPF_ADDR_STATUS: prdata <= status_word;
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // fpf_protect

// ----------------------------------------------------------------
// one-time programmable bit cell
// ----------------------------------------------------------------
module fpf_otp_bit #(
    parameter RESET_VALUE = 1'b0
) (
    input  wire sys_clk_in,
    input  wire rst_n_in,
    input  wire wr_in,
    input  wire data_in,
    output wire bit_out
);

    reg bit_ff;
    reg nxt_bit;

    // a one-time bit only ever moves from 0 to 1; a write of 0 is lost
    // this also covers a bit that is writable only while it reads 0
    always @* begin
        nxt_bit = bit_ff;
        if (wr_in && data_in) begin
            nxt_bit = 1'b1;
        end
    end

    // limitation: the value is volatile here; the real cell keeps it
    // across power cycles, so reset stands in for power-up only
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            bit_ff <= RESET_VALUE;
        end else begin
            bit_ff <= nxt_bit;
        end
    end

    assign bit_out = bit_ff;

endmodule // fpf_otp_bit

// ----------------------------------------------------------------
// volatile suspend flag
// ----------------------------------------------------------------
module fpf_susp_flag (
    input  wire sys_clk_in,
    input  wire rst_n_in,
    input  wire set_in,
    input  wire clear_in,
    output wire flag_out
);

    reg flag_ff;
    reg nxt_flag;

    // suspend and resume in one cycle leave the flag set, so a
    // suspend is never lost behind a late resume
    // both pulses come from logic on this clock, so no synchroniser
    always @* begin
        nxt_flag = flag_ff;
        if (clear_in) begin
            nxt_flag = 1'b0;
        end
        if (set_in) begin
            nxt_flag = 1'b1;
        end
    end

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag_out = flag_ff;

endmodule // fpf_susp_flag

// ===== verif/fpf_monitor.sv
`timescale 1ns/1ps
module fpf_monitor (
    input wire        sys_clk_in,
    input wire        rst_n_in,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        op_req_in,
    input wire        op_allow_out,
    input wire        op_deny_out,
    input wire        reset_on_hold_pin_out
);
    wire m = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
    wire rs = psel && !penable && !pwrite;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    answer_once_a: assert property (
        op_req_in |=> op_allow_out ^ op_deny_out) else $error("bad answer");
    no_stray_a: assert property (
        !op_req_in |=> !(op_allow_out || op_deny_out)) else $error("stray");
    err_map_a: assert property (
        psel && penable |-> pslverr == !m) else $error("pslverr wrong");
    unmapped_zero_a: assert property (
        rs && !m |=> prdata == 32'h0) else $error("unmapped read data");
    pin_set_a: assert property (
        psel && penable && pwrite && paddr == 12'h000 && pwdata[0]
        |=> reset_on_hold_pin_out) else $error("pin not moved");
    pin_sticky_a: assert property (
        reset_on_hold_pin_out |=> reset_on_hold_pin_out) else $error("bit 0");
    pin_read_a: assert property (
        rs && paddr == 12'h000 |=> prdata[0] == reset_on_hold_pin_out
        && prdata[31:8] == 24'h0) else $error("function read wrong");
    reset_clear_a: assert property (
        $rose(rst_n_in) |-> !(op_allow_out || op_deny_out)
        && prdata == 32'h0) else $error("reset values");
    cover property (op_deny_out);
    cover property (pslverr);
    cover property ($rose(reset_on_hold_pin_out));
endmodule // fpf_monitor
bind fpf_protect fpf_monitor i_mon (.*);

// ===== verif/fpf_seq_model.sv
`timescale 1ns/1ps
module fpf_seq_model (
    input  wire       sys_clk_in,
    input  wire       go_in,
    input  wire [1:0] kind_in,
    input  wire [8:0] blk_in,
    output reg        op_req_in = 1'b0,
    output reg        op_is_chip_erase_in = 1'b0,
    output reg        op_is_info_row_in = 1'b0,
    output reg  [8:0] op_block_in = 9'h000,
    output wire [1:0] op_info_row_in
);
    // idle fields flip so a stale target never passes for a fresh one
    assign op_info_row_in = op_block_in[1:0];
    always @(posedge sys_clk_in) begin
        op_req_in <= go_in;
        op_is_chip_erase_in <= go_in ? kind_in == 2'h1 : !op_is_chip_erase_in;
        op_is_info_row_in <= go_in ? kind_in == 2'h0 : !op_is_info_row_in;
        op_block_in <= go_in ? blk_in : ~op_block_in;
    end
endmodule // fpf_seq_model

// ===== verif/flash_protect_function_reg_bench.sv
`timescale 1ns/1ps
module flash_protect_function_reg_bench;
    reg         sys_clk_in = 1'b0, rst_n_in = 1'b0, go_in = 1'b0, err, e;
    reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg         prog_suspend_in = 1'b0, prog_resume_in = 1'b0;
    reg         erase_suspend_in = 1'b0, erase_resume_in = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0, rd;
    reg  [1:0]  kind_in = 2'h0;
    reg  [8:0]  blk_in = 9'h000;
    reg  [3:0]  lv;
    reg  [7:0]  fr;
    wire [31:0] prdata;
    wire [8:0]  op_block_in;
    wire [1:0]  op_info_row_in;
    wire        pready, pslverr, op_req_in, op_is_chip_erase_in;
    wire        op_is_info_row_in, op_allow_out, op_deny_out;
    wire        reset_on_hold_pin_out;
    integer     n_errors = 0, n_compared = 0, cyc = 0, i, j, n;
    always #5 sys_clk_in = ~sys_clk_in;
    fpf_seq_model i_seq (.*);
    fpf_protect i_dut (.*);
    task chk(input [31:0] s, input [31:0] x);
        n_compared = n_compared + 1;
        if (s !== x) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in) penable <= 1'b1;
        @(posedge sys_clk_in);
        while (pready !== 1'b1) @(posedge sys_clk_in);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    function exp_deny(input [3:0] l, input [7:0] f, input [8:0] t,
                      input [1:0] c);
        integer k;
        k = 1 << (l - 1);
        if (c == 2'h0) exp_deny = f[4 + t[1:0]];
        else if (c == 2'h1) exp_deny = l != 4'h0;
        else if (l == 4'h0) exp_deny = 1'b0;
        else if (l >= 4'ha) exp_deny = 1'b1;
        else exp_deny = f[1] ? t < k : t >= 512 - k;
    endfunction
    task sweep;
        for (i = 0; i < 16; i = i + 1) begin
            lv = i[3:0];
            apb(1'b1, 12'h004, i);
            for (j = 0; j < 6; j = j + 1) begin
                n = 1 << (lv - 1);
                // boundary blocks first, then random kinds and targets
                blk_in <= j == 0 ? n - 1 : j == 1 ? 512 - n : $urandom;
                kind_in <= j < 2 ? 2'h2 : $urandom;
                go_in <= 1'b1;
                @(posedge sys_clk_in) go_in <= 1'b0;
                // the answer stands only in the cycle after the request
                @(posedge sys_clk_in);
                @(negedge sys_clk_in);
                e = exp_deny(lv, fr, blk_in, kind_in);
                chk({op_deny_out, op_allow_out}, {e, !e});
                @(posedge sys_clk_in);
            end
            apb(1'b0, 12'h004, 0);
            chk(rd, {28'h0, lv});
        end
        apb(1'b0, 12'h008, 0);
        chk(rd, {22'h0, e, 9'h000});
        $display("sweep done, function %h", fr);
    endtask
    task summarize(input integer extra);
        n_errors = n_errors + extra;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge sys_clk_in) if (++cyc == 5000) summarize(1);
    initial begin
        i = $urandom(81614);
        repeat (20) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        fr = 8'h00;
        apb(1'b0, 12'h000, 0);
        chk(rd, 32'h0);
        sweep;
        fr = 8'h02;
        apb(1'b1, 12'h000, fr);
        sweep;
        apb(1'b1, 12'h000, 32'hfd);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 0);
        fr = 8'hf3;
        chk(rd, fr);
        chk(reset_on_hold_pin_out, 1'b1);
        sweep;
        for (i = 0; i < 4; i = i + 1) begin
            {erase_resume_in, erase_suspend_in, prog_resume_in,
             prog_suspend_in} <= 4'h1 << i;
            @(posedge sys_clk_in) {erase_resume_in, erase_suspend_in,
                                   prog_resume_in, prog_suspend_in} <= 4'h0;
            @(posedge sys_clk_in);
            apb(1'b0, 12'h000, 0);
            chk(rd, i == 0 ? 8'hf7 : i == 2 ? 8'hfb : fr);
        end
        apb(1'b0, 12'h00c, 0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        $display("suspend and refusal tests done");
        summarize(0);
    end
endmodule // flash_protect_function_reg_bench
